// >>> src/node_ctrl_params.svh
// constants of the network node state and layer setting logic
// assumes a 100 MHz system clock and a decoded command stream
`ifndef NODE_CTRL_PARAMS_SVH
`define NODE_CTRL_PARAMS_SVH
`define NODE_ID_RESET     7'h70
`define RATE_IDX_RESET    4'h8
`define RATE_IDX_MAX      4'h8
`define NODE_ID_MIN       7'h01
`define NODE_ID_MAX       7'h7F
`define INIT_DONE_CYCLES  8'h10
`define VENDOR_ID_ARB     32'h0000_0A01 // arbitrary value
`define PRODUCT_ARB       32'h0000_0A02 // arbitrary value
`define REVISION_ARB      32'h0000_0A03 // arbitrary value
`endif

// >>> src/node_ctrl_pkg.sv
// types of the network node state logic
// assumes the constants header beside it
package node_ctrl_pkg;
	typedef enum logic [3:0] {
		ST_INIT    = 4'h1,
		ST_PREOP   = 4'h2,
		ST_OPER    = 4'h4,
		ST_STOPPED = 4'h8
	} nmt_state_t;
	typedef enum logic [2:0] {
		CMD_START    = 3'h1,
		CMD_STOP     = 3'h2,
		CMD_PREOP    = 3'h3,
		CMD_RST_NODE = 3'h4,
		CMD_RST_COMM = 3'h5
	} nmt_cmd_t;
	typedef enum logic [1:0] {
		LSS_WAIT = 2'h1,
		LSS_CONF = 2'h2
	} lss_state_t;
endpackage

// >>> src/lss_if.sv
// signals between the state core and the layer setting block
// single clock domain
`timescale 1ns/1ps
interface lss_if;
	logic       conf;
	logic [6:0] node_id;
	logic [3:0] rate_idx;
	modport core (input conf, input node_id, input rate_idx);
	modport lss  (output conf, output node_id, output rate_idx);
endinterface

// >>> src/lss_ctrl.sv
// layer setting services: waiting/configuration state, id and rate
// commands arrive already decoded, one-cycle pulses on sys_clk_i
`timescale 1ns/1ps
`include "node_ctrl_params.svh"
module lss_ctrl
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        sel_hit_i,
	input  wire logic        glob_conf_i,
	input  wire logic        glob_wait_i,
	input  wire logic        set_id_i,
	input  wire logic [6:0]  id_val_i,
	input  wire logic        set_rate_i,
	input  wire logic [3:0]  rate_val_i,
	output logic             cfg_ok_o,
	output logic             cfg_err_o,
	lss_if.lss               lss
);
	node_ctrl_pkg::lss_state_t state_reg;
	node_ctrl_pkg::lss_state_t state_next;
	logic [6:0] id_reg;
	logic [6:0] id_next;
	logic [3:0] rate_reg;
	logic [3:0] rate_next;
	logic       ok_reg;
	logic       ok_next;
	logic       err_reg;
	logic       err_next;

	always_comb
	begin
		state_next = state_reg;
		id_next    = id_reg;
		rate_next  = rate_reg;
		ok_next    = 1'b0;
		err_next   = 1'b0;
		case (state_reg)
			node_ctrl_pkg::LSS_WAIT:
			begin
				if (glob_conf_i || sel_hit_i)
					state_next = node_ctrl_pkg::LSS_CONF;
			end
			node_ctrl_pkg::LSS_CONF:
			begin
				if (set_id_i)
				begin
					if (id_val_i >= `NODE_ID_MIN && id_val_i <= `NODE_ID_MAX)
					begin
						id_next = id_val_i;
						ok_next = 1'b1;
					end
					else
						err_next = 1'b1;
				end
				else if (set_rate_i)
				begin
					if (rate_val_i <= `RATE_IDX_MAX)
					begin
						rate_next = rate_val_i;
						ok_next   = 1'b1;
					end
					else
						err_next = 1'b1;
				end
				if (glob_wait_i)
					state_next = node_ctrl_pkg::LSS_WAIT;
			end
			default: state_next = node_ctrl_pkg::LSS_WAIT;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= node_ctrl_pkg::LSS_WAIT;
			id_reg    <= `NODE_ID_RESET;
			rate_reg  <= `RATE_IDX_RESET;
			ok_reg    <= 1'b0;
			err_reg   <= 1'b0;
		end
		else if (ce_i)
		begin
			state_reg <= state_next;
			id_reg    <= id_next;
			rate_reg  <= rate_next;
			ok_reg    <= ok_next;
			err_reg   <= err_next;
		end
	end

	assign lss.conf     = (state_reg == node_ctrl_pkg::LSS_CONF);
	assign lss.node_id  = id_reg;
	assign lss.rate_idx = rate_reg;
	assign cfg_ok_o     = ok_reg;
	assign cfg_err_o    = err_reg;

	id_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		id_reg >= `NODE_ID_MIN)
		else $error("node id left legal range");
	rate_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rate_reg <= `RATE_IDX_MAX)
		else $error("rate index above 8");
	wait_no_change_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == node_ctrl_pkg::LSS_WAIT) |=> $stable(id_reg) && $stable(rate_reg))
		else $error("id or rate changed outside configuration");
endmodule

// >>> src/canopen_node_state_control.sv
// network management state, traffic gating and fixed process mapping
// frames arrive decoded from a can controller on the same clock
`timescale 1ns/1ps
`include "node_ctrl_params.svh"
module canopen_node_state_control
#(
	parameter logic [31:0] SERIAL_NUM = 32'h0000_0001
)
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        nmt_valid_i,
	input  wire logic [2:0]  nmt_cmd_i,
	input  wire logic [6:0]  nmt_target_i,
	input  wire logic        sdo_req_i,
	input  wire logic        sdo_write_i,
	input  wire logic [15:0] sdo_index_i,
	input  wire logic [31:0] sdo_wdata_i,
	output logic             sdo_ack_o,
	output logic             sdo_abort_o,
	output logic [31:0]      sdo_rdata_o,
	input  wire logic        sync_i,
	output logic             tpdo_valid_o,
	output logic [31:0]      tpdo_data_o,
	input  wire logic [31:0] meas_i,
	input  wire logic        rpdo_valid_i,
	input  wire logic [31:0] rpdo_data_i,
	output logic [31:0]      setpoint_o,
	output logic             setpoint_we_o,
	input  wire logic        map_write_i,
	output logic             map_reject_o,
	input  wire logic        lss_sel_i,
	input  wire logic [31:0] lss_vendor_i,
	input  wire logic [31:0] lss_product_i,
	input  wire logic [31:0] lss_rev_i,
	input  wire logic [31:0] lss_serial_i,
	input  wire logic        lss_glob_conf_i,
	input  wire logic        lss_glob_wait_i,
	input  wire logic        lss_set_id_i,
	input  wire logic [6:0]  lss_id_i,
	input  wire logic        lss_set_rate_i,
	input  wire logic [3:0]  lss_rate_i,
	output logic             lss_ok_o,
	output logic             lss_err_o,
	output logic             lss_conf_o,
	output logic [6:0]       node_id_o,
	output logic [3:0]       rate_idx_o,
	output logic [3:0]       nmt_state_o,
	output logic [31:0]      vendor_id_o,
	output logic [31:0]      product_o,
	output logic [31:0]      revision_o,
	output logic [31:0]      serial_o
);
	lss_if lss_bus ();
	node_ctrl_pkg::nmt_state_t st_reg;
	node_ctrl_pkg::nmt_state_t st_next;
	logic [7:0]  init_cnt_reg;
	logic [7:0]  init_cnt_next;
	logic        sdo_ack_reg;
	logic        sdo_ack_next;
	logic        sdo_abort_reg;
	logic        sdo_abort_next;
	logic [31:0] sdo_rdata_reg;
	logic [31:0] sdo_rdata_next;
	logic        tpdo_valid_reg;
	logic        tpdo_valid_next;
	logic [31:0] tpdo_data_reg;
	logic [31:0] tpdo_data_next;
	logic [31:0] setpoint_reg;
	logic [31:0] setpoint_next;
	logic        sp_we_reg;
	logic        sp_we_next;
	logic        rej_reg;
	logic        rej_next;
	logic        for_me;
	logic        sdo_ok;
	logic        pdo_ok;
	logic        sel_hit;

	// identity match for selective switch
	assign sel_hit = lss_sel_i && lss_vendor_i == `VENDOR_ID_ARB
		&& lss_product_i == `PRODUCT_ARB && lss_rev_i == `REVISION_ARB
		&& lss_serial_i == SERIAL_NUM;

	lss_ctrl u_lss
	(
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.sel_hit_i   (sel_hit),
		.glob_conf_i (lss_glob_conf_i),
		.glob_wait_i (lss_glob_wait_i),
		.set_id_i    (lss_set_id_i),
		.id_val_i    (lss_id_i),
		.set_rate_i  (lss_set_rate_i),
		.rate_val_i  (lss_rate_i),
		.cfg_ok_o    (lss_ok_o),
		.cfg_err_o   (lss_err_o),
		.lss         (lss_bus)
	);

	// traffic permitted per state
	assign sdo_ok = (st_reg == node_ctrl_pkg::ST_PREOP)
		|| (st_reg == node_ctrl_pkg::ST_OPER);
	assign pdo_ok = (st_reg == node_ctrl_pkg::ST_OPER);
	assign for_me = nmt_valid_i
		&& (nmt_target_i == 7'h00 || nmt_target_i == lss_bus.node_id);

	// network state machine
	always_comb
	begin
		st_next       = st_reg;
		init_cnt_next = init_cnt_reg;
		case (st_reg)
			node_ctrl_pkg::ST_INIT:
			begin
				if (init_cnt_reg == `INIT_DONE_CYCLES)
					st_next = node_ctrl_pkg::ST_PREOP;
				else
					init_cnt_next = init_cnt_reg + 8'h01;
			end
			node_ctrl_pkg::ST_PREOP, node_ctrl_pkg::ST_OPER, node_ctrl_pkg::ST_STOPPED:
			begin
				if (for_me)
				begin
					case (nmt_cmd_i)
						node_ctrl_pkg::CMD_START: st_next = node_ctrl_pkg::ST_OPER;
						node_ctrl_pkg::CMD_STOP:  st_next = node_ctrl_pkg::ST_STOPPED;
						node_ctrl_pkg::CMD_PREOP: st_next = node_ctrl_pkg::ST_PREOP;
						node_ctrl_pkg::CMD_RST_NODE, node_ctrl_pkg::CMD_RST_COMM:
						begin
							st_next       = node_ctrl_pkg::ST_INIT;
							init_cnt_next = 8'h00;
						end
						default: st_next = st_reg;
					endcase
				end
			end
			default:
			begin
				st_next       = node_ctrl_pkg::ST_INIT;
				init_cnt_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			st_reg       <= node_ctrl_pkg::ST_INIT;
			init_cnt_reg <= 8'h00;
		end
		else if (ce_i)
		begin
			st_reg       <= st_next;
			init_cnt_reg <= init_cnt_next;
		end
	end

	// service data, process data and mapping guard
	always_comb
	begin
		sdo_ack_next    = 1'b0;
		sdo_abort_next  = 1'b0;
		sdo_rdata_next  = sdo_rdata_reg;
		tpdo_valid_next = 1'b0;
		tpdo_data_next  = tpdo_data_reg;
		setpoint_next   = setpoint_reg;
		sp_we_next      = 1'b0;
		rej_next        = 1'b0;
		if (sdo_req_i && sdo_ok)
		begin
			sdo_ack_next = 1'b1;
			if (sdo_write_i)
				setpoint_next = sdo_wdata_i;
			else
				sdo_rdata_next = {16'h0000, sdo_index_i} == 32'h0000_0000
					? 32'h0000_0000 : tpdo_data_reg;
			sp_we_next = sdo_write_i;
		end
		else if (sdo_req_i)
			sdo_abort_next = 1'b1;
		if (sync_i && pdo_ok)
		begin
			tpdo_valid_next = 1'b1;
			tpdo_data_next  = meas_i;
		end
		if (rpdo_valid_i && pdo_ok)
		begin
			setpoint_next = rpdo_data_i;
			sp_we_next    = 1'b1;
		end
		if (map_write_i)
			rej_next = 1'b1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			sdo_ack_reg    <= 1'b0;
			sdo_abort_reg  <= 1'b0;
			sdo_rdata_reg  <= 32'h0000_0000;
			tpdo_valid_reg <= 1'b0;
			tpdo_data_reg  <= 32'h0000_0000;
			setpoint_reg   <= 32'h0000_0000;
			sp_we_reg      <= 1'b0;
			rej_reg        <= 1'b0;
		end
		else if (ce_i)
		begin
			sdo_ack_reg    <= sdo_ack_next;
			sdo_abort_reg  <= sdo_abort_next;
			sdo_rdata_reg  <= sdo_rdata_next;
			tpdo_valid_reg <= tpdo_valid_next;
			tpdo_data_reg  <= tpdo_data_next;
			setpoint_reg   <= setpoint_next;
			sp_we_reg      <= sp_we_next;
			rej_reg        <= rej_next;
		end
	end

	assign sdo_ack_o     = sdo_ack_reg;
	assign sdo_abort_o   = sdo_abort_reg;
	assign sdo_rdata_o   = sdo_rdata_reg;
	assign tpdo_valid_o  = tpdo_valid_reg;
	assign tpdo_data_o   = tpdo_data_reg;
	assign setpoint_o    = setpoint_reg;
	assign setpoint_we_o = sp_we_reg;
	assign map_reject_o  = rej_reg;
	assign lss_conf_o    = lss_bus.conf;
	assign node_id_o     = lss_bus.node_id;
	assign rate_idx_o    = lss_bus.rate_idx;
	assign nmt_state_o   = st_reg;
	assign vendor_id_o   = `VENDOR_ID_ARB; // arbitrary value
	assign product_o     = `PRODUCT_ARB; // arbitrary value
	assign revision_o    = `REVISION_ARB; // arbitrary value
	assign serial_o      = SERIAL_NUM;

	onehot_state_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$onehot(st_reg))
		else $error("state not one-hot");
	init_exit_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(st_reg == node_ctrl_pkg::ST_INIT && ce_i && init_cnt_reg == `INIT_DONE_CYCLES)
		|=> st_reg == node_ctrl_pkg::ST_PREOP)
		else $error("init did not advance to pre-operational");
	start_cmd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && for_me && nmt_cmd_i == node_ctrl_pkg::CMD_START
		&& st_reg != node_ctrl_pkg::ST_INIT) |=> st_reg == node_ctrl_pkg::ST_OPER)
		else $error("start command ignored");
	sdo_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && sdo_req_i && !sdo_ok) |=> sdo_abort_o && !sdo_ack_o)
		else $error("service data answered in wrong state");
	sdo_answer_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(sdo_ack_o && $past(ce_i)) |-> $past(sdo_req_i))
		else $error("unrequested service data answer");
	tpdo_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && sync_i && pdo_ok) |=> tpdo_valid_o && tpdo_data_o == $past(meas_i))
		else $error("transmit data not sent on sync");
	rpdo_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && rpdo_valid_i && pdo_ok) |=> setpoint_we_o && setpoint_o == $past(rpdo_data_i))
		else $error("receive data not written");
	remap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && map_write_i) |=> map_reject_o)
		else $error("remap request not refused");
	reset_id_a: assert property (@(posedge sys_clk_i)
		$fell(rst_i) |-> node_id_o == `NODE_ID_RESET && rate_idx_o == `RATE_IDX_RESET)
		else $error("wrong defaults after reset");
	sdo_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && sdo_req_i && sdo_ok && sdo_write_i && !(rpdo_valid_i && pdo_ok))
		|=> setpoint_we_o && setpoint_o == $past(sdo_wdata_i))
		else $error("service write not applied");
	stop_cmd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && for_me && nmt_cmd_i == node_ctrl_pkg::CMD_STOP
		&& st_reg != node_ctrl_pkg::ST_INIT) |=> st_reg == node_ctrl_pkg::ST_STOPPED)
		else $error("stop command ignored");
	preop_cmd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && for_me && nmt_cmd_i == node_ctrl_pkg::CMD_PREOP
		&& st_reg != node_ctrl_pkg::ST_INIT) |=> st_reg == node_ctrl_pkg::ST_PREOP)
		else $error("pre-operational command ignored");
	reset_cmd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && for_me && (nmt_cmd_i == node_ctrl_pkg::CMD_RST_NODE
		|| nmt_cmd_i == node_ctrl_pkg::CMD_RST_COMM) && st_reg != node_ctrl_pkg::ST_INIT)
		|=> st_reg == node_ctrl_pkg::ST_INIT)
		else $error("reset command ignored");
	init_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && st_reg == node_ctrl_pkg::ST_INIT && init_cnt_reg != `INIT_DONE_CYCLES)
		|=> st_reg == node_ctrl_pkg::ST_INIT)
		else $error("init left early");
	ce_freeze_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!ce_i |=> $stable(st_reg) && $stable(sdo_ack_o) && $stable(tpdo_valid_o))
		else $error("state moved while clock enable low");
	tpdo_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && !pdo_ok) |=> !tpdo_valid_o)
		else $error("transmit data outside operational");
	rpdo_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && !pdo_ok && !(sdo_req_i && sdo_ok && sdo_write_i))
		|=> !setpoint_we_o)
		else $error("receive data taken outside operational");
	oper_c: cover property (@(posedge sys_clk_i) st_reg == node_ctrl_pkg::ST_OPER && tpdo_valid_o);
	stop_c: cover property (@(posedge sys_clk_i) st_reg == node_ctrl_pkg::ST_STOPPED);
	lss_c:  cover property (@(posedge sys_clk_i) lss_ok_o);
	wr_c:   cover property (@(posedge sys_clk_i) sdo_ack_o && setpoint_we_o);
	abrt_c: cover property (@(posedge sys_clk_i) sdo_abort_o);
endmodule

// >>> tb/can_master_model.sv
// master side model: network commands, service and process data, layer setting
// drives on the falling edge of sys_clk_i; every strobe is a one-cycle pulse
`timescale 1ns/1ps
module can_master_model
(
	input  wire logic   sys_clk_i,
	output logic        nmt_valid_o,
	output logic [2:0]  nmt_cmd_o,
	output logic [6:0]  nmt_target_o,
	output logic        sdo_req_o,
	output logic        sdo_write_o,
	output logic [15:0] sdo_index_o,
	output logic [31:0] sdo_wdata_o,
	output logic        sync_o,
	output logic        rpdo_valid_o,
	output logic [31:0] rpdo_data_o,
	output logic        map_write_o,
	output logic        lss_sel_o,
	output logic [127:0] lss_ident_o,
	output logic        lss_glob_conf_o,
	output logic        lss_glob_wait_o,
	output logic        lss_set_id_o,
	output logic [6:0]  lss_id_o,
	output logic        lss_set_rate_o,
	output logic [3:0]  lss_rate_o
);
	logic [9:0] stb;
	assign {lss_set_rate_o, lss_set_id_o, lss_glob_wait_o, lss_glob_conf_o, lss_sel_o} = stb[9:5];
	assign {map_write_o, rpdo_valid_o, sync_o, sdo_req_o, nmt_valid_o} = stb[4:0];
	initial
	begin
		stb = '0;
		{nmt_cmd_o, nmt_target_o, sdo_write_o, sdo_index_o, sdo_wdata_o, rpdo_data_o} = '0;
		{lss_ident_o, lss_id_o, lss_rate_o} = '0;
	end
	// strobe held one cycle, released at the next falling edge
	task automatic fire(input int n);
		stb = 10'h001 << n;
		@(negedge sys_clk_i);
		stb = 10'h000;
	endtask
	// states past init are reached through network commands; pre-op is first reached through the init count
	task automatic nmt(input logic [2:0] c, input logic [6:0] t);
		@(negedge sys_clk_i);
		{nmt_cmd_o, nmt_target_o} = {c, t};
		fire(0);
		{nmt_cmd_o, nmt_target_o} = ~{c, t};
	endtask
	// service writes only in pre-op, where no receive data overwrites them
	task automatic sdo_wr(input logic [15:0] i, input logic [31:0] d);
		@(negedge sys_clk_i);
		{sdo_index_o, sdo_wdata_o, sdo_write_o} = {i, d, 1'b1};
		fire(1);
		{sdo_index_o, sdo_wdata_o, sdo_write_o} = ~{i, d, 1'b1};
	endtask
	// read request; write flag stays low
	task automatic sdo(input logic [15:0] i);
		@(negedge sys_clk_i);
		sdo_index_o = i;
		fire(1);
		sdo_index_o = ~i;
	endtask
	task automatic pulse(input int n);
		@(negedge sys_clk_i);
		fire(n);
	endtask
	task automatic rpdo(input logic [31:0] d);
		@(negedge sys_clk_i);
		rpdo_data_o = d;
		fire(3);
		rpdo_data_o = ~d;
	endtask
	task automatic sel(input logic [127:0] v);
		@(negedge sys_clk_i);
		lss_ident_o = v;
		fire(5);
		lss_ident_o = ~v;
	endtask
	// single node on the bus while its identifier is set
	task automatic set_id(input logic [6:0] v);
		@(negedge sys_clk_i);
		lss_id_o = v;
		fire(8);
		lss_id_o = ~v;
	endtask
	task automatic set_rate(input logic [3:0] v);
		@(negedge sys_clk_i);
		lss_rate_o = v;
		fire(9);
		lss_rate_o = ~v;
	endtask
endmodule

// >>> tb/tb_canopen_node_state_control.sv
// self-checking bench of the node state block against fixed expected values and a queue
// partner model plays the network master; one 100 MHz clock
`timescale 1ns/1ps
`include "node_ctrl_params.svh"
module tb_canopen_node_state_control;
	localparam logic [31:0] SERIAL = 32'h0000_5A3C; // arbitrary value
	logic         sys_clk_i, rst_i, ce_i, nmt_valid_i, sdo_req_i, sdo_write_i, sync_i;
	logic         rpdo_valid_i, map_write_i, lss_sel_i, lss_glob_conf_i, lss_glob_wait_i;
	logic         lss_set_id_i, lss_set_rate_i, sdo_ack_o, sdo_abort_o, tpdo_valid_o;
	logic         setpoint_we_o, map_reject_o, lss_ok_o, lss_err_o, lss_conf_o;
	logic [2:0]   nmt_cmd_i;
	logic [6:0]   nmt_target_i, lss_id_i, node_id_o;
	logic [3:0]   lss_rate_i, rate_idx_o, nmt_state_o;
	logic [15:0]  sdo_index_i;
	logic [31:0]  sdo_wdata_i, sdo_rdata_o, tpdo_data_o, meas_i, rpdo_data_i, setpoint_o;
	logic [31:0]  vendor_id_o, product_o, revision_o, serial_o, r;
	logic [127:0] ident;
	int           n_errors, comparisons, seed, k;
	logic [31:0]  tx_q[$];
	always #5 sys_clk_i = ~sys_clk_i;
	canopen_node_state_control #(.SERIAL_NUM(SERIAL)) canopen_node_state_control_i (
		.sys_clk_i, .rst_i, .ce_i, .nmt_valid_i, .nmt_cmd_i, .nmt_target_i, .sdo_req_i,
		.sdo_write_i, .sdo_index_i, .sdo_wdata_i, .sdo_ack_o, .sdo_abort_o, .sdo_rdata_o,
		.sync_i, .tpdo_valid_o, .tpdo_data_o, .meas_i, .rpdo_valid_i, .rpdo_data_i,
		.setpoint_o, .setpoint_we_o, .map_write_i, .map_reject_o, .lss_sel_i,
		.lss_vendor_i(ident[127:96]), .lss_product_i(ident[95:64]), .lss_rev_i(ident[63:32]),
		.lss_serial_i(ident[31:0]), .lss_glob_conf_i, .lss_glob_wait_i, .lss_set_id_i,
		.lss_id_i, .lss_set_rate_i, .lss_rate_i, .lss_ok_o, .lss_err_o, .lss_conf_o,
		.node_id_o, .rate_idx_o, .nmt_state_o, .vendor_id_o, .product_o, .revision_o, .serial_o);
	can_master_model can_master_model_i (.sys_clk_i, .nmt_valid_o(nmt_valid_i),
		.nmt_cmd_o(nmt_cmd_i), .nmt_target_o(nmt_target_i), .sdo_req_o(sdo_req_i),
		.sdo_write_o(sdo_write_i), .sdo_index_o(sdo_index_i), .sdo_wdata_o(sdo_wdata_i),
		.sync_o(sync_i), .rpdo_valid_o(rpdo_valid_i), .rpdo_data_o(rpdo_data_i),
		.map_write_o(map_write_i), .lss_sel_o(lss_sel_i), .lss_ident_o(ident),
		.lss_glob_conf_o(lss_glob_conf_i), .lss_glob_wait_o(lss_glob_wait_i),
		.lss_set_id_o(lss_set_id_i), .lss_id_o(lss_id_i), .lss_set_rate_o(lss_set_rate_i),
		.lss_rate_o(lss_rate_i));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_state(input logic [3:0] s);
		for (k = 0; k < 40 && nmt_state_o !== s; k++)
			@(negedge sys_clk_i);
		if (k == 40)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	initial
	begin
		sys_clk_i = 1'b0;
		rst_i = 1'b1;
		ce_i = 1'b1;
		meas_i = '0;
		seed = 53;
		repeat (8) @(negedge sys_clk_i);
		rst_i = 1'b0;
		chk(nmt_state_o, node_ctrl_pkg::ST_INIT);
		chk({node_id_o, rate_idx_o}, {`NODE_ID_RESET, 4'h8});
		chk({vendor_id_o, serial_o}, {`VENDOR_ID_ARB, SERIAL});
		chk({product_o, revision_o}, {`PRODUCT_ARB, `REVISION_ARB});
		can_master_model_i.sdo(16'h2102);
		chk(sdo_abort_o, 1'b1);
		can_master_model_i.nmt(node_ctrl_pkg::CMD_START, 7'h00);
		chk(nmt_state_o, node_ctrl_pkg::ST_INIT);
		$display("test init done");
		wait_state(node_ctrl_pkg::ST_PREOP);
		can_master_model_i.sdo(16'h2103);
		chk({sdo_ack_o, sdo_abort_o}, 2'b10);
		r = $random(seed);
		can_master_model_i.sdo_wr(16'h2201, r);
		chk({sdo_ack_o, setpoint_we_o, setpoint_o}, {2'b11, r});
		can_master_model_i.pulse(2);
		chk({tpdo_valid_o, sdo_ack_o}, 2'b00);
		can_master_model_i.rpdo(32'h0000_00A5);
		chk({setpoint_we_o, setpoint_o}, {1'b0, r});
		can_master_model_i.nmt(node_ctrl_pkg::CMD_START, 7'h05);
		chk(nmt_state_o, node_ctrl_pkg::ST_PREOP);
		can_master_model_i.nmt(node_ctrl_pkg::CMD_START, `NODE_ID_RESET);
		chk(nmt_state_o, node_ctrl_pkg::ST_OPER);
		$display("test preop done");
		repeat (4)
		begin
			meas_i = $random(seed);
			tx_q.push_back(meas_i);
			can_master_model_i.pulse(2);
			chk({tpdo_valid_o, tpdo_data_o}, {1'b1, tx_q[0]});
			r = $random(seed);
			can_master_model_i.rpdo(r);
			chk({setpoint_we_o, setpoint_o}, {1'b1, r});
			can_master_model_i.sdo(16'h2102);
			chk({sdo_ack_o, sdo_rdata_o}, {1'b1, tx_q.pop_front()});
		end
		ce_i = 1'b0;
		can_master_model_i.pulse(2);
		can_master_model_i.nmt(node_ctrl_pkg::CMD_STOP, 7'h00);
		chk({sdo_ack_o, tpdo_valid_o, nmt_state_o}, {2'b10, node_ctrl_pkg::ST_OPER});
		ce_i = 1'b1;
		$display("test freeze done");
		can_master_model_i.pulse(4);
		chk(map_reject_o, 1'b1);
		can_master_model_i.nmt(node_ctrl_pkg::CMD_STOP, 7'h00);
		chk(nmt_state_o, node_ctrl_pkg::ST_STOPPED);
		can_master_model_i.sdo(16'h2102);
		chk(sdo_abort_o, 1'b1);
		can_master_model_i.pulse(2);
		chk(tpdo_valid_o, 1'b0);
		can_master_model_i.nmt(node_ctrl_pkg::CMD_PREOP, 7'h00);
		chk(nmt_state_o, node_ctrl_pkg::ST_PREOP);
		can_master_model_i.nmt(node_ctrl_pkg::CMD_RST_COMM, 7'h00);
		chk(nmt_state_o, node_ctrl_pkg::ST_INIT);
		$display("test states done");
		can_master_model_i.set_id(7'h71);
		chk({lss_ok_o, node_id_o}, {1'b0, `NODE_ID_RESET});
		can_master_model_i.pulse(6);
		chk(lss_conf_o, 1'b1);
		can_master_model_i.set_id(7'h71);
		chk({lss_ok_o, node_id_o}, {1'b1, 7'h71});
		can_master_model_i.set_id(7'h00);
		chk({lss_err_o, node_id_o}, {1'b1, 7'h71});
		for (int i = 9; i >= 0; i--)
		begin
			can_master_model_i.set_rate(4'(i));
			chk({lss_ok_o, lss_err_o, rate_idx_o}, {i <= 8, i > 8, 4'((i > 8) ? 8 : i)});
		end
		can_master_model_i.pulse(7);
		chk(lss_conf_o, 1'b0);
		can_master_model_i.sel({`VENDOR_ID_ARB, `PRODUCT_ARB, `REVISION_ARB, SERIAL ^ 32'h1});
		chk(lss_conf_o, 1'b0);
		can_master_model_i.sel({`VENDOR_ID_ARB, `PRODUCT_ARB, `REVISION_ARB, SERIAL});
		chk(lss_conf_o, 1'b1);
		$display("test layer setting done");
		rst_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		rst_i = 1'b0;
		chk(nmt_state_o, node_ctrl_pkg::ST_INIT);
		chk({lss_conf_o, node_id_o, rate_idx_o}, {1'b0, `NODE_ID_RESET, `RATE_IDX_RESET});
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
